// ===== hdl/ddr_mode_burst_config.sv
`timescale 1ns/100ps
`include "ddr_cfg_defs.svh"

// Overview of operation
// - address bit 3 at mode programming picks sequential or interleaved order.
// - sequential order counts the low column upward, modulo burst length.
// - interleaved order is start low column XOR beat count.
// - two-beat burst: block from column bit 1 up, bit 0 starts.
// - four-beat burst: block from column bit 2 up, bits 1:0 start.
// - eight-beat burst: block from column bit 3 up, bits 2:0 start.
// - bursts wrap inside their aligned block, never carrying upward.
// - read latency of 2, 2.5 or 3 cycles is programmable.
// - read at edge n with latency m gives first data at edge n+m.
// - mode bits 11:7 zero selects normal; bits 6:0 load settings.
// - bank bits 01 load the extended register, held until rewritten.
// - self refresh disables the dll on entry, re-enables on exit.
// - extended bit 0 low enables the dll, high disables it.
// - extended bit 1 low gives normal drive, high gives weak drive.
// - bank bits 00 select main register: length, order, latency, mode.
// - dll reset bit clears itself; other stored bits persist.
// - lengths 2, 4, 8 for both orders, same for reads and writes.
module ddr_mode_burst_config #(
	parameter int COL_W = 10
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// command pins, sampled on the rising clock edge into two synchroniser stages
	input wire logic mode_set_pin,
	input wire logic read_pin,
	input wire logic write_pin,
	input wire logic self_refresh_pin,
	input wire logic bank_select_bit0,
	input wire logic bank_select_bit1,
	input wire logic [`ADDR_W-1:0] addr_pin,
	// column stream of the burst
	output logic beat_valid,
	input wire logic beat_ready,
	output logic [COL_W-1:0] beat_column,
	output logic beat_last,
	output logic beat_write,
	// read data timing
	output logic read_data_start,
	output logic read_half_cycle,
	// active configuration
	output logic [3:0] burst_beats,
	output ddr_cfg_pkg::burst_order_t burst_order_select,
	output logic [2:0] read_latency_field,
	output logic output_drive_select,
	output logic dll_enabled,
	output logic dll_locked,
	output logic dll_reset_pulse
);
	import ddr_cfg_pkg::*;

	localparam int BUF_W = COL_W + 2;

	typedef struct packed {
		logic mode_set;
		logic read;
		logic write;
		logic self_refresh;
		logic ba1;
		logic ba0;
		logic [`ADDR_W-1:0] addr;
	} pins_t;

	typedef struct packed {
		// two synchroniser stages for every pin
		pins_t pin1;
		pins_t pin2;
		// stored mode settings
		logic [`MAIN_W-1:0] main_mode_config;
		logic [`EXT_W-1:0] extended_mode_config;
		logic [3:0] beats;
		// dll control and lock wait
		logic dll_rst;
		logic dll_on;
		logic [`LOCK_CNT_W-1:0] lock_cnt;
		logic locked;
		// read latency pipeline
		logic [1:0] lat_sr;
		logic rd_first;
		logic rd_half;
		// burst column generator
		gen_state_t gen;
		logic [COL_W-1:0] start_col;
		logic [2:0] beat;
		logic [2:0] last_beat;
		burst_order_t order;
		logic is_write;
	} state_t;

	state_t q;
	state_t d;
	pins_t p;
	// decoded mode command
	logic [4:0] op_mode;
	logic op_normal;
	logic op_dll_reset;
	logic mrs_main;
	logic mrs_ext;
	logic dll_now;
	logic rd_cmd;
	// burst generator
	logic cmd;
	logic [2:0] start_low;
	logic [2:0] idx;
	wire logic [2:0] col_low;
	logic [COL_W-1:0] col;
	logic buf_in_ready;
	logic [BUF_W-1:0] buf_out;

	function automatic logic [3:0] decode_beats(input logic [2:0] code);
		logic [3:0] n;
		n = 4'h0;
		unique case (code)
			`BL_CODE_2: n = 4'h2;
			`BL_CODE_4: n = 4'h4;
			`BL_CODE_8: n = 4'h8;
			default: n = 4'h0;
		endcase
		return n;
	endfunction : decode_beats

	// position of a beat inside the aligned block; the sum wraps modulo eight and
	// the block mask trims it to the burst length
	function automatic logic [2:0] beat_index(input burst_order_t order,
		input logic [2:0] start, input logic [2:0] beat);
		logic [2:0] i;
		i = 3'h0;
		if (order == ORDER_INTERLEAVED) begin
			i = start ^ beat;
		end else begin
			i = start + beat;
		end
		return i;
	endfunction : beat_index

	always_comb begin
		d = q;
		d.pin1.mode_set = mode_set_pin;
		d.pin1.read = read_pin;
		d.pin1.write = write_pin;
		d.pin1.self_refresh = self_refresh_pin;
		d.pin1.ba1 = bank_select_bit1;
		d.pin1.ba0 = bank_select_bit0;
		d.pin1.addr = addr_pin;
		d.pin2 = q.pin1;
		p = q.pin2;

		// mode programming
		op_mode = p.addr[`MAIN_OP_MSB:`MAIN_OP_LSB];
		op_normal = (op_mode == `OP_NORMAL);
		op_dll_reset = (op_mode == `OP_DLL_RESET);
		mrs_main = p.mode_set & ~p.ba1 & ~p.ba0;
		mrs_ext = p.mode_set & ~p.ba1 & p.ba0;
		// the reset bit is never stored, so it reads back cleared
		d.dll_rst = 1'b0;
		// reserved or test operating modes are ignored as a whole
		if (mrs_main && (op_normal || op_dll_reset)) begin
			d.main_mode_config = p.addr[`MAIN_W-1:0];
			d.beats = decode_beats(p.addr[`MAIN_BL_MSB:`MAIN_BL_LSB]);
			d.dll_rst = op_dll_reset;
		end
		if (mrs_ext) begin
			d.extended_mode_config = p.addr[`EXT_W-1:0];
		end

		// dll follows the enable bit, forced off during self refresh
		dll_now = ~q.extended_mode_config[`EXT_DLL_BIT] & ~p.self_refresh;
		d.dll_on = dll_now;
		if (!dll_now || !q.dll_on || q.dll_rst) begin
			// lock wait restarts on every enable and every dll reset
			d.lock_cnt = '0;
			d.locked = 1'b0;
		end else if (q.lock_cnt == `LOCK_CNT_W'(`DLL_LOCK_CYCLES - 1)) begin
			d.locked = 1'b1;
		end else begin
			d.lock_cnt = q.lock_cnt + `LOCK_CNT_W'(1);
		end

		// read latency: stage 0 is one edge after the read registers
		rd_cmd = p.read & ~p.self_refresh;
		d.lat_sr = {q.lat_sr[0], rd_cmd};
		unique case (q.main_mode_config[`MAIN_CL_MSB:`MAIN_CL_LSB])
			`CL_CODE_2: begin
				d.rd_first = q.lat_sr[0];
				d.rd_half = 1'b0;
			end
			`CL_CODE_25: begin
				// half-cycle data launches off the falling edge after n+2
				d.rd_first = q.lat_sr[0];
				d.rd_half = q.lat_sr[0];
			end
			`CL_CODE_3: begin
				d.rd_first = q.lat_sr[1];
				d.rd_half = 1'b0;
			end
			default: begin
				d.rd_first = 1'b0;
				d.rd_half = 1'b0;
			end
		endcase

		// burst column generator
		start_low = q.start_col[2:0];
		idx = beat_index(q.order, start_low, q.beat);

		// commands are dropped in self refresh and while the length code is reserved
		cmd = (p.read | p.write) & ~p.self_refresh & (q.beats != 4'h0);
		if (cmd) begin
			// a new command cuts the running burst short
			d.gen = GEN_RUN;
			d.start_col = p.addr[COL_W-1:0];
			d.beat = 3'h0;
			d.last_beat = 3'(q.beats - 4'h1);
			d.order = burst_order_t'(q.main_mode_config[`MAIN_BT_BIT]);
			d.is_write = p.write;
		end else if (q.gen == GEN_RUN && buf_in_ready) begin
			if (q.beat == q.last_beat) begin
				d.gen = GEN_IDLE;
			end else begin
				d.beat = q.beat + 3'h1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			q.pin1 <= '0;
			q.pin2 <= '0;
			q.main_mode_config <= `MAIN_RST;
			q.extended_mode_config <= `EXT_RST;
			// two beats, matching the length code held in the main reset value
			q.beats <= 4'h2;
			q.dll_rst <= 1'b0;
			q.dll_on <= 1'b0;
			q.lock_cnt <= '0;
			q.locked <= 1'b0;
			q.lat_sr <= 2'h0;
			q.rd_first <= 1'b0;
			q.rd_half <= 1'b0;
			q.gen <= GEN_IDLE;
			q.start_col <= '0;
			q.beat <= 3'h0;
			q.last_beat <= 3'h0;
			q.order <= ORDER_SEQUENTIAL;
			q.is_write <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// two entries so a stall on the drain side loses no beat
	beat_skid_buffer #(
		.W(BUF_W)
	) u_beat_buf (
		.clock(clock),
		.rst_n(rst_n),
		.in_valid(q.gen == GEN_RUN),
		.in_ready(buf_in_ready),
		.in_data({q.is_write, q.beat == q.last_beat, col}),
		.out_valid(beat_valid),
		.out_ready(beat_ready),
		.out_data(buf_out)
	);

	// last_beat is length-1 and doubles as the in-block mask: inside the block a
	// column bit follows the beat index, above it the start column stays untouched
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_col_bit
			assign col_low[gi] = q.last_beat[gi] ? idx[gi] : start_low[gi];
		end
	endgenerate
	assign col = {q.start_col[COL_W-1:3], col_low};

	// fields of the beat leaving the buffer
	assign beat_write = buf_out[BUF_W-1];
	assign beat_last = buf_out[BUF_W-2];
	assign beat_column = buf_out[COL_W-1:0];
	// status and configuration, all straight from flops
	assign read_data_start = q.rd_first;
	assign read_half_cycle = q.rd_half;
	assign burst_beats = q.beats;
	assign burst_order_select = burst_order_t'(q.main_mode_config[`MAIN_BT_BIT]);
	assign read_latency_field = q.main_mode_config[`MAIN_CL_MSB:`MAIN_CL_LSB];
	assign output_drive_select = q.extended_mode_config[`EXT_DS_BIT];
	assign dll_enabled = q.dll_on;
	assign dll_locked = q.locked;
	assign dll_reset_pulse = q.dll_rst;

endmodule : ddr_mode_burst_config

// ===== hdl/ddr_cfg_defs.svh
`ifndef DDR_CFG_DEFS_SVH
`define DDR_CFG_DEFS_SVH

// command address pins carried into the mode registers
`define ADDR_W 13
// main mode register field positions
`define MAIN_W 7
`define MAIN_BL_MSB 2
`define MAIN_BL_LSB 0
`define MAIN_BT_BIT 3
`define MAIN_CL_MSB 6
`define MAIN_CL_LSB 4
`define MAIN_OP_MSB 11
`define MAIN_OP_LSB 7
// operating mode codes
`define OP_NORMAL 5'h00
`define OP_DLL_RESET 5'h02
// burst length codes
`define BL_CODE_2 3'h1
`define BL_CODE_4 3'h2
`define BL_CODE_8 3'h3
// read latency codes
`define CL_CODE_2 3'h2
`define CL_CODE_3 3'h3
`define CL_CODE_25 3'h6
// extended mode register field positions
`define EXT_W 13
`define EXT_DLL_BIT 0
`define EXT_DS_BIT 1
// reset values
`define MAIN_RST 7'h21
`define EXT_RST 13'h0000
// dll lock wait, in clock cycles
`define DLL_LOCK_CYCLES 200
`define LOCK_CNT_W 8

`endif

// ===== hdl/ddr_cfg_pkg.sv
package ddr_cfg_pkg;

	typedef enum logic {
		GEN_IDLE = 1'b0,
		GEN_RUN = 1'b1
	} gen_state_t;

	typedef enum logic {
		ORDER_SEQUENTIAL = 1'b0,
		ORDER_INTERLEAVED = 1'b1
	} burst_order_t;

endpackage : ddr_cfg_pkg

// ===== hdl/beat_skid_buffer.sv
`timescale 1ns/100ps
module beat_skid_buffer #(
	parameter int W = 12
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	typedef struct packed {
		logic out_valid;
		logic [W-1:0] out_data;
		logic skid_valid;
		logic [W-1:0] skid_data;
	} buf_state_t;

	buf_state_t q;
	buf_state_t d;
	logic push;

	always_comb begin
		d = q;
		push = in_valid & ~q.skid_valid;
		if (!q.out_valid || out_ready) begin
			// output slot frees up: the skid entry goes first to keep order
			d.out_valid = q.skid_valid | push;
			d.out_data = q.skid_valid ? q.skid_data : in_data;
			d.skid_valid = 1'b0;
		end else if (push) begin
			d.skid_valid = 1'b1;
			d.skid_data = in_data;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ready is registered, so the second entry absorbs the word in flight
	assign in_ready = ~q.skid_valid;
	assign out_valid = q.out_valid;
	assign out_data = q.out_data;

endmodule : beat_skid_buffer

// ===== tb/cfg_monitor.sv
`timescale 1ns/100ps
module cfg_monitor #(parameter int COL_W = 10) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// watched pins
	input wire logic self_refresh_pin,
	input wire logic beat_valid,
	input wire logic beat_ready,
	input wire logic [COL_W-1:0] beat_column,
	input wire logic beat_last,
	input wire logic read_data_start,
	input wire logic read_half_cycle,
	input wire logic [3:0] burst_beats,
	input wire logic [2:0] read_latency_field,
	input wire logic dll_enabled,
	input wire logic dll_locked,
	input wire logic dll_reset_pulse
);
	logic first_q;
	logic [COL_W-1:0] col_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			first_q <= 1'b1;
			col_q <= '0;
		end else if (beat_valid && beat_ready) begin
			first_q <= beat_last;
			col_q <= beat_column;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	half_start_a: assert property (read_half_cycle |-> read_data_start)
		else $error("half flag alone");
	half_code_a: assert property (read_half_cycle |-> read_latency_field == 3'h6)
		else $error("half flag code");
	beats_legal_a: assert property (burst_beats inside {4'h0, 4'h2, 4'h4, 4'h8})
		else $error("beats value");
	beat_hold_a: assert property (beat_valid && !beat_ready |=> beat_valid
		&& $stable(beat_column) && $stable(beat_last)) else $error("beat dropped");
	block_wrap_a: assert property (beat_valid && !first_q |->
		(beat_column >> 3) == (col_q >> 3)) else $error("block carry");
	self_refresh_a: assert property (self_refresh_pin [*4] |-> !dll_enabled)
		else $error("dll on in self refresh");
	lock_wait_a: assert property ($rose(dll_enabled) |-> !dll_locked [*8])
		else $error("early lock");
	reset_clear_a: assert property (dll_reset_pulse |=> !dll_reset_pulse)
		else $error("reset bit stuck");
	cover property (read_half_cycle);
	cover property (beat_valid && beat_ready && beat_last);
	cover property (dll_reset_pulse);
endmodule : cfg_monitor
bind ddr_mode_burst_config cfg_monitor #(.COL_W(COL_W)) mon (.clock(clock), .rst_n(rst_n),
	.self_refresh_pin(self_refresh_pin), .beat_valid(beat_valid), .beat_ready(beat_ready),
	.beat_column(beat_column), .beat_last(beat_last), .read_data_start(read_data_start),
	.read_half_cycle(read_half_cycle), .burst_beats(burst_beats),
	.read_latency_field(read_latency_field), .dll_enabled(dll_enabled),
	.dll_locked(dll_locked), .dll_reset_pulse(dll_reset_pulse));

// ===== tb/beat_sink.sv
`timescale 1ns/100ps
module beat_sink (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// bench control and stream side
	input wire logic stall,
	output logic beat_ready
);
	logic [1:0] cnt_q;
	// ready one cycle in three while stalling, so the two-entry buffer fills
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) cnt_q <= 2'h0;
		else cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
	end
	assign beat_ready = !stall || (cnt_q == 2'h2);
endmodule : beat_sink

// ===== tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import ddr_cfg_pkg::*;
	logic clock = 0, rst_n = 0, ms = 0, rd = 0, wr = 0, sr = 0, ba0 = 0, ba1 = 0, st = 0;
	logic bv, br, bl, bw, rs, rh, ds, de, dk, dp;
	logic [12:0] ad = 0;
	logic [9:0] bc;
	logic [3:0] bb;
	burst_order_t bo;
	logic [2:0] cl;
	int mismatches = 0, cmp_count = 0, cyc = 0, pc = 0, n, a, b, c, x;
	ddr_mode_burst_config uut (.clock(clock), .rst_n(rst_n), .mode_set_pin(ms),
		.read_pin(rd), .write_pin(wr), .self_refresh_pin(sr), .bank_select_bit0(ba0),
		.bank_select_bit1(ba1), .addr_pin(ad), .beat_valid(bv), .beat_ready(br),
		.beat_column(bc), .beat_last(bl), .beat_write(bw), .read_data_start(rs),
		.read_half_cycle(rh), .burst_beats(bb), .burst_order_select(bo),
		.read_latency_field(cl), .output_drive_select(ds), .dll_enabled(de),
		.dll_locked(dk), .dll_reset_pulse(dp));
	beat_sink sink (.clock(clock), .rst_n(rst_n), .stall(st), .beat_ready(br));
	initial begin
		forever #10 clock = ~clock;
	end
	// counted on the falling edge, where the design's outputs have settled
	always @(negedge clock) begin
		cyc++;
		if (dp === 1'b1) pc++;
		if (cyc == 9000) begin
			mismatches++;
			stop_test();
		end
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	task automatic mset(input logic [1:0] ba, input logic [12:0] v);
		@(negedge clock);
		{ba1, ba0} = ba;
		ad = v;
		ms = 1'b1;
		@(negedge clock);
		ms = 1'b0;
		repeat (6) @(negedge clock);
	endtask : mset
	task automatic cmd(input logic w, input logic [12:0] v);
		@(negedge clock);
		ad = v;
		{wr, rd} = {w, !w};
		@(negedge clock);
		{wr, rd} = 2'b00;
	endtask : cmd
	task automatic lock(output int k);
		for (k = 0; k < 260 && dk !== 1'b1; k++)
			@(negedge clock);
	endtask : lock
	task automatic t_burst(input logic [2:0] lc, input logic o, input logic w);
		logic [9:0] m, e;
		int k;
		m = (10'h1 << lc) - 10'h1;
		mset(2'h0, {6'h0, 3'h2, o, lc});
		chk(bb, 16'(m) + 16'h1);
		chk(bo, o);
		cmd(w, 13'h3f5);
		k = 0;
		for (int i = 0; i < 50 && k <= m; i++) begin
			@(negedge clock);
			if ((bv & br) === 1'b1) begin
				e = (10'h3f5 & ~m) | ((o ? 10'h3f5 ^ 10'(k) : 10'h3f5 + 10'(k)) & m);
				chk(bc, e);
				chk({bw, bl}, {w, 10'(k) == m});
				k++;
			end
		end
		chk(16'(k), 16'(m) + 16'h1);
		$display("burst %0d order %0d done", lc, o);
	endtask : t_burst
	task automatic t_lat(input logic [2:0] code, output int d);
		logic h;
		d = -1;
		h = 1'b0;
		mset(2'h0, {6'h0, code, 4'h1});
		chk(cl, code);
		cmd(1'b0, 13'h0);
		for (int i = 1; i < 12; i++) begin
			@(negedge clock);
			if (rs === 1'b1 && d < 0) begin
				d = i;
				h = rh;
			end
		end
		chk(h, code == 3'h6);
		$display("latency code %0h done", code);
	endtask : t_lat
	task automatic t_mode();
		int p;
		mset(2'h0, 13'h0183);
		chk(bb, 16'h2);
		p = pc;
		mset(2'h0, 13'h0123);
		chk({bb, dk}, {4'h8, 1'b0});
		chk(16'(pc - p), 16'h1);
		mset(2'h0, 13'h0022);
		chk(bb, 16'h4);
		lock(n);
		chk(n > 170 && n < 200, 1'b1);
		$display("mode done");
	endtask : t_mode
	task automatic t_ext();
		mset(2'h1, 13'h0003);
		chk({ds, de}, 2'b10);
		mset(2'h2, 13'h0000);
		chk({ds, de, bb}, {2'b10, 4'h4});
		mset(2'h1, 13'h0000);
		chk({ds, de, dk}, 3'b010);
		lock(n);
		chk(n > 185 && n < 205, 1'b1);
		$display("extended done");
	endtask : t_ext
	task automatic t_sr();
		sr = 1'b1;
		cmd(1'b0, 13'h0);
		repeat (6) @(negedge clock);
		chk({de, dk, bv}, 3'b000);
		sr = 1'b0;
		lock(n);
		chk(n > 190 && n < 215, 1'b1);
		$display("self refresh done");
	endtask : t_sr
	initial begin
		repeat (12) @(posedge clock);
		@(negedge clock);
		rst_n = 1'b1;
		chk({bb, cl, bo, ds, dk}, {4'h2, 3'h2, 3'h0});
		lock(n);
		chk(dk, 1'b1);
		for (int i = 1; i < 4; i++) begin
			st = i[0];
			t_burst(3'(i), 1'b0, i[1]);
			t_burst(3'(i), 1'b1, !i[0]);
		end
		st = 1'b0;
		t_lat(3'h2, a);
		t_lat(3'h3, b);
		t_lat(3'h6, c);
		t_lat(3'h4, x);
		chk(16'(b - a), 16'h1);
		chk(16'(c - a), 16'h0);
		chk(16'(x), 16'hffff);
		$display("latency done");
		t_mode();
		t_ext();
		t_sr();
		stop_test();
	end
endmodule : tb_top
